// File: src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

	// ----------------------------------------
	// Scan codes and counts
	// ----------------------------------------
	localparam logic [1:0] SCAN_UP = 2'h0;
	localparam logic [1:0] SCAN_REPEAT = 2'h1;
	localparam logic [1:0] SCAN_RSVD = 2'h2;
	localparam logic [1:0] SCAN_SINGLE = 2'h3;
	localparam logic [3:0] REPEAT_COUNT = 4'h8;
	localparam logic [3:0] SINGLE_COUNT = 4'h1;
	localparam int RES_BITS = 10;
	localparam int FIFO_DEPTH = 8;
	localparam logic [9:0] BIPOLAR_FLIP = 10'h200;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int REF_WAKE_MS = 10;
	localparam int REF_WAKE_CYCLES = REF_WAKE_MS * 1000 * 1000 * CLK_MHZ / 1000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CONV = 3'h1,
		ST_STORE = 3'h3,
		ST_NEXT = 3'h7,
		ST_DONE = 3'h2
	} scan_state_t;

	typedef struct packed {
		logic [1:0] scan;
		logic cs;
		logic single_ended;
	} cfg_t;

	typedef struct packed {
		logic [2:0] ref_sel;
		logic clk_ext;
		logic bipolar;
	} setup_t;

	typedef struct packed {
		logic addr_ok;
		logic stop;
		logic rstart;
		logic nack;
	} bus_evt_t;

	typedef struct packed {
		scan_state_t st;
		cfg_t cfg;
		setup_t setup;
		logic [3:0] cnt;
		logic ch;
		logic [9:0] res;
		logic pwr;
		logic ref_on;
		logic ref_oe;
		logic [19:0] ref_cnt;
		logic ref_ready;
		logic scl_oe;
		logic scl_o;
		logic adc_start;
		logic flush;
		logic s1;
		logic s2;
		logic s3;
	} ctrl_state_t;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam cfg_t CFG_RST = '{scan: SCAN_UP, cs: 1'b0, single_ended: 1'b1};
	localparam setup_t SETUP_RST = '{ref_sel: 3'h0, clk_ext: 1'b0, bipolar: 1'b0};

endpackage

// File: src/adc_scan_power_reference_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Result buffer
// ----------------------------------------
module result_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// Contents not reset; undefined until written
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic [AW:0] wr_d;
	logic [AW:0] rd_d;
	logic empty_q;
	logic [WIDTH-1:0] head_q;
	logic push;
	logic full;
	logic empty;

	// Extra pointer bit separates full from empty
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty = empty_q;
	assign push = in_valid && !full;
	assign in_ready = !full;
	// Flag and head word registered so the outputs leave flip-flops
	assign out_valid = !empty_q;
	assign out_data = head_q;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Next pointers; clear drops everything stored
	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		if (push) begin
			wr_d = wr_q + 1'b1;
		end
		if (out_ready && !empty_q) begin
			rd_d = rd_q + 1'b1;
		end
		if (sys_rst || clear) begin
			wr_d = '0;
			rd_d = '0;
		end
	end

	// Head word forwarded when a push lands on the slot read next
	always_ff @(posedge clk) begin
		wr_q <= wr_d;
		rd_q <= rd_d;
		empty_q <= (wr_d == rd_d);
		if (push && (wr_q[AW-1:0] == rd_d[AW-1:0])) begin
			head_q <= in_data;
		end else begin
			head_q <= mem[rd_d[AW-1:0]];
		end
	end
endmodule

// Notes on behaviour
// - Scan code 00 converts inputs upward from input 0 to channel select.
// - Scan code 01, internal clock: eight conversions of the selected input.
// - Scan code 11, internal clock: one conversion of the selected input.
// - External clock: codes 01 and 11 convert endlessly until not-acknowledge.
// - Reset: single-ended, unipolar, one conversion on input 0, internal clock, supply ref.
// - Result memory is uninitialised after power-up.
// - Idle powers analog down; internal reference follows reference select.
// - Internal clock: power down once all scan results are stored.
// - Internal-clock results survive shutdown until stop or repeated start.
// - Idle waits for address; valid address byte powers analog up.
// - Internal reference with low bit 1, once on, stays on until reference select changes.
// - Reference pin output is high impedance during shutdown.
// - Select top bit 0: middle bit picks supply or pin, reference off.
// - Select top bits 11: internal reference driven out on reference pin.
// - With internal reference, low bit keeps it on or off between conversions.
// - Results are 10-bit: straight binary unipolar, two's complement bipolar.
// - Clock bit 0 selects internal oscillator, 1 serial clock; default 0.
// - Internal clock: hold serial clock low until scan results stored.
module adc_scan_power_reference_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter int REF_WAKE = REF_WAKE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cfg_wr,
	input wire cfg_t cfg_in,
	input wire logic setup_wr,
	input wire setup_t setup_in,
	input wire bus_evt_t evt,
	input wire logic scl_pin,
	output logic scl_o,
	output logic scl_oe,
	output logic adc_start,
	output logic adc_ch,
	input wire logic adc_done,
	input wire logic [RES_BITS-1:0] adc_code,
	output logic analog_pwr,
	output logic ref_on,
	output logic ref_oe,
	output logic ref_ready,
	output cfg_t cfg_out,
	output setup_t setup_out,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [RES_BITS-1:0] rd_data
);
	ctrl_state_t q;
	ctrl_state_t d;
	logic fifo_ready;
	logic scl_rise;
	logic forever_scan;
	logic [3:0] total;
	logic [3:0] cnt_inc;
	logic scan_end;

	// ----------------------------------------
	// Scan bookkeeping
	// ----------------------------------------
	// Edge taken from the second and third stages only
	assign scl_rise = q.s2 && !q.s3;
	assign forever_scan = q.setup.clk_ext && (q.cfg.scan != SCAN_UP);
	assign cnt_inc = q.cnt + 4'h1;
	// Reserved code treated as single; undefined by design
	always_comb begin
		case (q.cfg.scan)
			SCAN_UP: total = {3'h0, q.cfg.cs} + 4'h1;
			SCAN_REPEAT: total = REPEAT_COUNT;
			default: total = SINGLE_COUNT;
		endcase
	end
	assign scan_end = !forever_scan && (cnt_inc == total);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.s1 = scl_pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.adc_start = 1'b0;
		d.flush = 1'b0;
		d.scl_o = 1'b0;
		// Configuration writes
		if (cfg_wr) begin
			d.cfg = cfg_in;
		end
		if (setup_wr) begin
			d.setup = setup_in;
		end
		case (q.st)
			ST_IDLE: begin
				if (evt.addr_ok) begin
					d.pwr = 1'b1;
					d.ch = (q.cfg.scan == SCAN_UP) ? 1'b0 : q.cfg.cs;
					d.cnt = 4'h0;
					d.adc_start = 1'b1;
					d.scl_oe = !q.setup.clk_ext;
					d.flush = 1'b1;
					d.st = ST_CONV;
				end
			end
			ST_CONV: begin
				if (adc_done) begin
					// Converter delivers offset binary
					d.res = q.setup.bipolar ? (adc_code ^ BIPOLAR_FLIP) : adc_code;
					d.st = ST_STORE;
				end
			end
			ST_STORE: begin
				// Full buffer stalls the scan here
				if (fifo_ready) begin
					d.cnt = cnt_inc;
					if (q.cfg.scan == SCAN_UP) begin
						d.ch = q.ch + 1'b1;
					end
					d.st = scan_end ? ST_DONE : ST_NEXT;
				end
			end
			ST_NEXT: begin
				// External mode paces on the serial clock
				if (!q.setup.clk_ext || scl_rise) begin
					d.adc_start = 1'b1;
					d.st = ST_CONV;
				end
			end
			ST_DONE: begin
				d.pwr = 1'b0;
				d.scl_oe = 1'b0;
				d.st = ST_IDLE;
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
		// External mode also idles on not-acknowledge, stop or repeated start
		if (q.setup.clk_ext && q.st != ST_IDLE && (evt.nack || evt.stop || evt.rstart)) begin
			d.pwr = 1'b0;
			d.scl_oe = 1'b0;
			d.st = ST_IDLE;
		end
		// Stored results dropped here and when a new scan starts
		if (evt.stop || evt.rstart) begin
			d.flush = 1'b1;
		end
		// Reference control
		d.ref_on = q.setup.ref_sel[2] && (q.setup.ref_sel[0] || d.pwr);
		d.ref_oe = (q.setup.ref_sel[2:1] == 2'b11) && d.pwr;
		if (!d.ref_on) begin
			d.ref_cnt = 20'h0;
		end else if (q.ref_cnt != REF_WAKE[19:0]) begin
			d.ref_cnt = q.ref_cnt + 20'h1;
		end
		d.ref_ready = d.ref_on && (q.ref_cnt == REF_WAKE[19:0]);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.cfg <= CFG_RST;
			q.setup <= SETUP_RST;
			// Synchroniser starts at the idle-high level: no false edge after reset
			q.s1 <= 1'b1;
			q.s2 <= 1'b1;
			q.s3 <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Results buffer; memory left unreset
	result_fifo #(
		.WIDTH(RES_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(q.flush),
		.in_valid(q.st == ST_STORE),
		.in_ready(fifo_ready),
		.in_data(q.res),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// Outputs
	assign scl_o = q.scl_o;
	assign scl_oe = q.scl_oe;
	assign adc_start = q.adc_start;
	assign adc_ch = q.ch;
	assign analog_pwr = q.pwr;
	assign ref_on = q.ref_on;
	assign ref_oe = q.ref_oe;
	assign ref_ready = q.ref_ready;
	assign cfg_out = q.cfg;
	assign setup_out = q.setup;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence seq_wake;
		(q.st == ST_IDLE) && evt.addr_ok && !(q.setup.clk_ext && evt.nack);
	endsequence
	sequence seq_powered;
		q.pwr && (q.st == ST_CONV) && q.adc_start;
	endsequence

	a_idle_power_off: assert property ((q.st == ST_IDLE) |-> !q.pwr)
		else $error("analog powered while idle");
	a_addr_wakes: assert property (seq_wake |=> seq_powered)
		else $error("address did not power up");
	a_done_release: assert property ((q.st == ST_DONE) |=> !q.pwr && !q.scl_oe)
		else $error("no shutdown after scan");
	a_scl_hold_low: assert property ((q.st inside {ST_CONV, ST_STORE, ST_NEXT})
		&& !q.setup.clk_ext |-> q.scl_oe)
		else $error("serial clock released mid scan");
	a_repeat_eight: assert property ((q.st == ST_DONE) && (q.cfg.scan == SCAN_REPEAT)
		&& !q.setup.clk_ext |-> q.cnt == 4'h8)
		else $error("repeat scan count wrong");
	a_single_once: assert property ((q.st == ST_DONE) && (q.cfg.scan == SCAN_SINGLE)
		&& !q.setup.clk_ext |-> q.cnt == 4'h1)
		else $error("single scan count wrong");
	a_scan_up_len: assert property ((q.st == ST_DONE) && (q.cfg.scan == SCAN_UP)
		|-> q.cnt == {3'h0, q.cfg.cs} + 4'h1)
		else $error("upward scan length wrong");
	a_ext_endless: assert property (q.setup.clk_ext && (q.cfg.scan != SCAN_UP)
		|-> q.st != ST_DONE)
		else $error("external scan ended by itself");
	a_ref_stays_on: assert property (q.setup.ref_sel[2] && q.setup.ref_sel[0]
		&& $stable(q.setup) |=> q.ref_on)
		else $error("kept-on reference dropped");
	a_ref_hiz_down: assert property (!q.pwr |-> !q.ref_oe)
		else $error("reference driven in shutdown");
	a_bipolar_code: assert property ((q.st == ST_CONV) && adc_done && q.setup.bipolar
		|=> q.res == ($past(adc_code) ^ BIPOLAR_FLIP))
		else $error("bipolar coding wrong");
endmodule

`default_nettype wire

// File: verification/conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// Converter stand-in: answers each start after a fixed delay
module conv_model #(
	parameter int DLY = 5,
	parameter logic [9:0] CODE0 = 10'h05A,
	parameter logic [9:0] CODE1 = 10'h2A5
) (
	input wire logic clk,
	input wire logic adc_start,
	input wire logic adc_ch,
	output logic adc_done,
	output logic [9:0] adc_code
);
	int cnt = 0;
	logic ch = 1'b0;
	initial begin
		adc_done = 1'b0;
		adc_code = 10'h155;
	end
	// Code only means something with done; it flips otherwise so stale reads show
	always @(posedge clk) begin
		adc_done <= 1'b0;
		adc_code <= ~adc_code;
		if (adc_start) begin
			cnt <= DLY;
			ch <= adc_ch;
		end else if (cnt == 1) begin
			adc_done <= 1'b1;
			adc_code <= ch ? CODE1 : CODE0;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// File: verification/test_adc_scan_power_reference_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_scan_power_reference_ctrl;
	import adc_ctrl_pkg::*;
	localparam int WAKE = 20;
	localparam logic [9:0] C0 = 10'h05A;
	localparam logic [9:0] C1 = 10'h2A5;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cfg_wr = 1'b0;
	cfg_t cfg_in = CFG_RST;
	logic setup_wr = 1'b0;
	setup_t setup_in = SETUP_RST;
	bus_evt_t evt = '0;
	logic scl_pin = 1'b1;
	logic scl_run = 1'b0;
	logic rd_ready = 1'b0;
	logic scl_oe, adc_start, adc_ch, adc_done, analog_pwr, ref_on, ref_oe, ref_ready, rd_valid;
	logic [9:0] adc_code, rd_data;
	logic scl_o;
	cfg_t cfg_out;
	setup_t setup_out;
	int n_errors = 0;
	int check_count = 0;
	int n_starts = 0;
	int s0 = 0;
	cfg_t cs_tab[4] = '{'{SCAN_UP, 1'b1, 1'b1}, '{SCAN_REPEAT, 1'b1, 1'b1},
		'{SCAN_SINGLE, 1'b0, 1'b1}, '{SCAN_UP, 1'b0, 1'b1}};
	int n_tab[4] = '{2, 8, 1, 1};
	logic [2:0] sel_tab[3] = '{3'h2, 3'h6, 3'h7};

	adc_scan_power_reference_ctrl #(.REF_WAKE(WAKE)) adc_scan_power_reference_ctrl_i (
		.clk, .sys_rst, .cfg_wr, .cfg_in, .setup_wr, .setup_in, .evt, .scl_pin, .scl_o,
		.scl_oe, .adc_start, .adc_ch, .adc_done, .adc_code, .analog_pwr, .ref_on, .ref_oe,
		.ref_ready, .cfg_out, .setup_out, .rd_valid, .rd_ready, .rd_data);
	conv_model #(.CODE0(C0), .CODE1(C1)) conv_model_i (
		.clk, .adc_start, .adc_ch, .adc_done, .adc_code);

	// ----------------------------------------
	// Clocks and monitors
	// ----------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end
	// Serial clock runs only inside a frame; toggles land on clk falling edges
	always begin
		#40;
		scl_pin = scl_run ? ~scl_pin : 1'b1;
	end
	always @(posedge clk) if (adc_start === 1'b1) n_starts++;
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("Error at %0t: watchdog", $time);
		finish_test();
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic write_setup(input setup_t s);
		@(posedge clk) setup_in <= s;
		setup_wr <= 1'b1;
		@(posedge clk) setup_wr <= 1'b0;
	endtask
	task automatic pulse_evt(input bus_evt_t e);
		@(posedge clk) evt <= e;
		@(posedge clk) evt <= '0;
	endtask
	task automatic start_scan(input cfg_t c);
		@(posedge clk) cfg_in <= c;
		cfg_wr <= 1'b1;
		@(posedge clk) cfg_wr <= 1'b0;
		evt.addr_ok <= 1'b1;
		@(posedge clk) evt.addr_ok <= 1'b0;
		#1;
		check(analog_pwr, 1, "power up");
		check(scl_oe, !setup_out.clk_ext, "stretch");
		check(scl_o, 0, "scl low");
	endtask
	// Bounded so a scan that never ends is reported, not hung on
	task automatic wait_idle();
		int i;
		i = 0;
		while (analog_pwr === 1'b1 && i < 500) begin
			tick(1);
			i++;
		end
		check(i < 500, 1, "scan end");
		check({analog_pwr, scl_oe, ref_oe}, 0, "shutdown");
	endtask
	task automatic pop(input logic [9:0] exp);
		check(rd_valid, 1, "held");
		check(rd_data, exp, "word");
		@(posedge clk) rd_ready <= 1'b1;
		@(posedge clk) rd_ready <= 1'b0;
		#1;
	endtask
	task automatic finish_test();
		$display("Checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		tick(1);
		check(cfg_out, {SCAN_UP, 1'b0, 1'b1}, "cfg rst");
		check(setup_out, 0, "setup rst");
		check({analog_pwr, rd_valid, ref_on, scl_oe}, 0, "idle rst");
		$display("Test reset done");
		// Internal clock scans; results read only after shutdown
		foreach (n_tab[t]) begin
			start_scan(cs_tab[t]);
			wait_idle();
			tick(30);
			for (int k = 0; k < n_tab[t]; k++) begin
				pop((cs_tab[t].scan == SCAN_UP && k == 0) ? C0 : (cs_tab[t].cs ? C1 : C0));
			end
			check(rd_valid, 0, "count");
			$display("Test scan %0d done", t);
		end
		write_setup('{ref_sel: 3'h0, clk_ext: 1'b0, bipolar: 1'b1});
		start_scan('{scan: SCAN_SINGLE, cs: 1'b1, single_ended: 1'b1});
		wait_idle();
		check(rd_data, C1 ^ 10'h200, "bipolar");
		pulse_evt('{addr_ok: 1'b0, stop: 1'b0, rstart: 1'b1, nack: 1'b0});
		tick(2);
		check(rd_valid, 0, "flush");
		$display("Test bipolar done");
		foreach (sel_tab[t]) begin
			write_setup('{ref_sel: sel_tab[t], clk_ext: 1'b0, bipolar: 1'b0});
			start_scan(CFG_RST);
			tick(2);
			check(ref_on, sel_tab[t][2], "ref scan");
			check(ref_oe, sel_tab[t][2] & sel_tab[t][1], "ref pin");
			wait_idle();
			tick(WAKE + 5);
			check({ref_on, ref_ready}, {2{sel_tab[t] == 3'h7}}, "ref idle");
			$display("Test ref %0d done", t);
		end
		write_setup(SETUP_RST);
		tick(2);
		check(ref_on, 0, "ref off");
		// External clock: codes 01 and 11 both convert until not-acknowledge
		write_setup('{ref_sel: 3'h0, clk_ext: 1'b1, bipolar: 1'b0});
		for (int t = 1; t < 4; t += 2) begin
			@(posedge clk) rd_ready <= 1'b1;
			scl_run <= 1'b1;
			start_scan('{scan: 2'(t), cs: 1'b0, single_ended: 1'b1});
			s0 = n_starts;
			tick(400);
			check(n_starts - s0 > 20, 1, "endless");
			check(scl_oe, 0, "no stretch");
			pulse_evt('{addr_ok: 1'b0, stop: 1'b0, rstart: 1'b0, nack: 1'b1});
			scl_run <= 1'b0;
			rd_ready <= 1'b0;
			tick(3);
			check(analog_pwr, 0, "ext shutdown");
			$display("Test external %0d done", t);
		end
		// Mid-run reset must restore the power-up defaults
		@(posedge clk) sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		tick(1);
		check(cfg_out, {SCAN_UP, 1'b0, 1'b1}, "cfg rerst");
		check(setup_out, 0, "setup rerst");
		check({analog_pwr, rd_valid, scl_oe}, 0, "idle rerst");
		$display("Test rereset done");
		finish_test();
	end
endmodule
`default_nettype wire
